// ---- hdl/csp_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "csp_cfg.svh"

// Summary of operation
// - Bus master requests pass through in every power state.
// - Suspend config bit 4 low gates internal clocks during Active Idle.
// - Suspend config bit 3 adds the ISA clock to that gating.
// - Suspend config bit 2 enables processor power-down while suspended.
// - Suspend request asserts on command, drops on interrupt or management event.
// - Suspend config bit 0 toggles the suspend request by off/on counts.
// - Bit 1 chooses speedup timer or hold until speedup-disable read on MGMT_INTERRUPT_EVENT.
// - Bit 1 has no effect while modulation is disabled.
// - Deep suspend output asserts only after the suspend handshake completes.
// - Timers and MGMT_INTERRUPT_EVENT response keep running while system clocks are stopped.
// - Any MGMT_INTERRUPT_EVENT or unmasked interrupt drops the deep suspend output.
// - After deep suspend, request stays active for the programmed 0-15 ms delay.
// - Management interrupt output stays asserted throughout the re-sync delay.
// - Deep suspend pin is sampled after reset; that level is its inactive level.
// - Top 16 bytes of the window always map the ACPI timer.
// - Clock stop bit 0 makes a suspend command go to full deep suspend.
// - Modulation off/on counts are 8-bit counts of 32 us intervals.
module csp_ctrl #(
  parameter int unsigned TICK32_CYC = `CSP_TICK32_CYC,
  parameter int unsigned MS_CYC     = `CSP_MS_CYC,
  parameter int unsigned BM_W       = 4
) (
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic             ce_i,
  input  wire logic             cfg_rd_i,
  input  wire logic             cfg_wr_i,
  input  wire logic             cfg_func_i,
  input  wire logic [7:0]       cfg_addr_i,
  input  wire logic [31:0]      cfg_wdata_i,
  output logic      [31:0]      cfg_rdata_o,
  input  wire logic             mem_rd_i,
  input  wire logic [31:0]      mem_addr_i,
  output logic                  mem_hit_o,
  output logic      [31:0]      mem_rdata_o,
  input  wire logic             cpu_suspend_ack_n_i,
  input  wire logic             cpu_interrupt_request_i,
  input  wire logic             irq_unmasked_i,
  input  wire logic             mgmt_interrupt_event_i,
  input  wire logic             clk_32k_i,
  input  wire logic [BM_W-1:0]  bm_req_i,
  output logic      [BM_W-1:0]  bm_req_o,
  output logic                  cpu_suspend_request_n_o,
  output logic                  mgmt_interrupt_n_o,
  input  wire logic             deep_suspend_clock_gate_i,
  output logic                  deep_suspend_clock_gate_o,
  output logic                  deep_suspend_clock_gate_oe_o,
  output logic                  core_clock_gate_o,
  output logic                  isa_clock_gate_o,
  output logic                  cpu_power_down_o
);

  function automatic logic cfg_hit(input logic f, input logic [7:0] a,
                                   input logic want_f, input logic [7:0] want_a);
    cfg_hit = (f == want_f) && (a == want_a);
  endfunction : cfg_hit

  function automatic logic [7:0] dec_sat(input logic [7:0] v);
    dec_sat = (v == 8'h00) ? 8'h00 : v - 8'h01;
  endfunction : dec_sat

  // Synchronised pins.
  logic [5:0] pins_q;
  logic       ack_q;
  logic       cpu_interrupt_request_q;
  logic       irq_q;
  logic       smi_q;
  logic       k32_q;
  logic       deep_pin_q;

  csp_sync #(
    .W   (6),
    .RST (6'h01)
  ) u_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .d_i      ({deep_suspend_clock_gate_i, clk_32k_i, mgmt_interrupt_event_i,
                irq_unmasked_i, cpu_interrupt_request_i, cpu_suspend_ack_n_i}),
    .q_o      (pins_q)
  );

  assign ack_q      = ~pins_q[0];
  assign cpu_interrupt_request_q     = pins_q[1];
  assign irq_q      = pins_q[2];
  assign smi_q      = pins_q[3];
  assign k32_q      = pins_q[4];
  assign deep_pin_q = pins_q[5];

  logic cpu_interrupt_request_d_ff;
  logic irq_d_ff;
  logic smi_d_ff;
  logic k32_d_ff;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cpu_interrupt_request_d_ff <= 1'b0;
      irq_d_ff  <= 1'b0;
      smi_d_ff  <= 1'b0;
      k32_d_ff  <= 1'b0;
    end
    else if (ce_i)
    begin
      cpu_interrupt_request_d_ff <= cpu_interrupt_request_q;
      irq_d_ff  <= irq_q;
      smi_d_ff  <= smi_q;
      k32_d_ff  <= k32_q;
    end
  end

  logic smi_ev;
  logic irq_ev;
  logic wake;
  assign smi_ev = smi_q & ~smi_d_ff;
  assign irq_ev = (cpu_interrupt_request_q & ~cpu_interrupt_request_d_ff) | (irq_q & ~irq_d_ff);
  assign wake   = smi_q | cpu_interrupt_request_q | irq_q;

  // Registers.
  logic [23:0]         win_base_ff;
  csp_pkg::csp_byte_t  irq_spd_ff;
  csp_pkg::csp_byte_t  mod_off_ff;
  csp_pkg::csp_byte_t  mod_on_ff;
  csp_pkg::csp_byte_t  cpu_suspend_request_n_cfg_ff;
  csp_pkg::csp_byte_t  clk_stop_ff;
  logic                cpu_suspend_request_n_cmd_ff;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      win_base_ff <= `CSP_RST_WIN_BASE;
      irq_spd_ff  <= `CSP_RST_BYTE;
      mod_off_ff  <= `CSP_RST_BYTE;
      mod_on_ff   <= `CSP_RST_BYTE;
      cpu_suspend_request_n_cfg_ff <= `CSP_RST_BYTE;
      clk_stop_ff <= `CSP_RST_BYTE;
      cpu_suspend_request_n_cmd_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      cpu_suspend_request_n_cmd_ff <= cfg_wr_i && cfg_hit(cfg_func_i, cfg_addr_i, `CSP_FUNC_CTRL,
                                         `CSP_OFS_CPU_SUSPEND_REQUEST_N_CMD);
      if (cfg_wr_i)
      begin
        if (cfg_hit(cfg_func_i, cfg_addr_i, `CSP_FUNC_WIN, `CSP_OFS_WIN_BASE))
          win_base_ff <= cfg_wdata_i[31:`CSP_WIN_LSB];
        if (cfg_hit(cfg_func_i, cfg_addr_i, `CSP_FUNC_CTRL, `CSP_OFS_IRQ_SPD))
          irq_spd_ff <= cfg_wdata_i[7:0];
        if (cfg_hit(cfg_func_i, cfg_addr_i, `CSP_FUNC_CTRL, `CSP_OFS_MOD_OFF))
          mod_off_ff <= cfg_wdata_i[7:0];
        if (cfg_hit(cfg_func_i, cfg_addr_i, `CSP_FUNC_CTRL, `CSP_OFS_MOD_ON))
          mod_on_ff <= cfg_wdata_i[7:0];
        if (cfg_hit(cfg_func_i, cfg_addr_i, `CSP_FUNC_CTRL, `CSP_OFS_CPU_SUSPEND_REQUEST_N_CFG))
          cpu_suspend_request_n_cfg_ff <= cfg_wdata_i[7:0] & `CSP_SC_USED_MASK;
        if (cfg_hit(cfg_func_i, cfg_addr_i, `CSP_FUNC_CTRL, `CSP_OFS_CLK_STOP))
          clk_stop_ff <= cfg_wdata_i[7:0] & `CSP_CS_USED_MASK;
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cfg_rdata_o <= 32'h0000_0000;
    else if (ce_i && cfg_rd_i)
    begin
      cfg_rdata_o <= 32'h0000_0000;
      if (cfg_hit(cfg_func_i, cfg_addr_i, `CSP_FUNC_WIN, `CSP_OFS_WIN_BASE))
        cfg_rdata_o <= {win_base_ff, 8'h00};
      if (cfg_hit(cfg_func_i, cfg_addr_i, `CSP_FUNC_CTRL, `CSP_OFS_IRQ_SPD))
        cfg_rdata_o <= {24'h000000, irq_spd_ff};
      if (cfg_hit(cfg_func_i, cfg_addr_i, `CSP_FUNC_CTRL, `CSP_OFS_MOD_OFF))
        cfg_rdata_o <= {24'h000000, mod_off_ff};
      if (cfg_hit(cfg_func_i, cfg_addr_i, `CSP_FUNC_CTRL, `CSP_OFS_MOD_ON))
        cfg_rdata_o <= {24'h000000, mod_on_ff};
      if (cfg_hit(cfg_func_i, cfg_addr_i, `CSP_FUNC_CTRL, `CSP_OFS_CPU_SUSPEND_REQUEST_N_CFG))
        cfg_rdata_o <= {24'h000000, cpu_suspend_request_n_cfg_ff};
      if (cfg_hit(cfg_func_i, cfg_addr_i, `CSP_FUNC_CTRL, `CSP_OFS_CLK_STOP))
        cfg_rdata_o <= {24'h000000, clk_stop_ff};
    end
  end

  logic mod_en;
  assign mod_en = cpu_suspend_request_n_cfg_ff[`CSP_SC_MOD_EN];

  // Timebases: the 32 us one free-runs, the ms one restarts on a deep-suspend wake; both keep counting while the system clocks are
  // gated, since this block runs from the always-on clock.
  logic [$clog2(TICK32_CYC)-1:0] pre32_ff;
  logic [$clog2(MS_CYC)-1:0]     prems_ff;
  logic                          tick32;
  logic                          tickms;
  logic                          ms_restart;

  assign tick32 = (pre32_ff == '0);
  assign tickms = (prems_ff == '0);

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pre32_ff <= '0;
      prems_ff <= '0;
    end
    else if (ce_i)
    begin
      pre32_ff <= tick32 ? ($clog2(TICK32_CYC))'(TICK32_CYC - 1) : pre32_ff - 1'b1;
      if (ms_restart || tickms)
        prems_ff <= ($clog2(MS_CYC))'(MS_CYC - 1);
      else
        prems_ff <= prems_ff - 1'b1;
    end
  end

  // Memory window decode.
  logic win_hit;
  logic spd_clr;
  assign win_hit = (mem_addr_i[31:`CSP_WIN_LSB] == win_base_ff);
  assign spd_clr = mem_rd_i && win_hit && (mem_addr_i[7:0] == `CSP_WIN_SPD_CLR);

  logic [23:0] acpi_tmr_ff;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      acpi_tmr_ff <= 24'h000000;
      mem_hit_o   <= 1'b0;
      mem_rdata_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      if (k32_q && !k32_d_ff)
        acpi_tmr_ff <= acpi_tmr_ff + 24'h000001;
      mem_hit_o   <= mem_rd_i && win_hit;
      mem_rdata_o <= 32'h0000_0000;
      if (mem_rd_i && win_hit && mem_addr_i[7:4] == `CSP_WIN_TIMER_HI)
        mem_rdata_o <= {8'h00, acpi_tmr_ff};
    end
  end

  // Speedup handling.
  csp_pkg::csp_byte_t irq_cnt_ff;
  logic               smi_hold_ff;
  logic               speedup;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      irq_cnt_ff  <= 8'h00;
      smi_hold_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      if (mod_en && (irq_ev || (smi_ev && !cpu_suspend_request_n_cfg_ff[`CSP_SC_SMI_HOLD])))
        irq_cnt_ff <= irq_spd_ff;
      else if (tickms)
        irq_cnt_ff <= dec_sat(irq_cnt_ff);
      if (!mod_en)
        smi_hold_ff <= 1'b0;
      else if (smi_ev && cpu_suspend_request_n_cfg_ff[`CSP_SC_SMI_HOLD])
        smi_hold_ff <= 1'b1;
      else if (spd_clr)
        smi_hold_ff <= 1'b0;
    end
  end

  assign speedup = (irq_cnt_ff != 8'h00) || smi_hold_ff;

  // Suspend state machine.
  csp_pkg::csp_state_e state_ff;
  csp_pkg::csp_state_e nxt_state;
  logic [3:0]          resync_ff;
  logic                mod_assert;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      csp_pkg::CSP_IDLE:
        if (cpu_suspend_request_n_cmd_ff)
          nxt_state = csp_pkg::CSP_REQ;
      csp_pkg::CSP_REQ:
        if (wake)
          nxt_state = csp_pkg::CSP_IDLE;
        else if (ack_q)
          nxt_state = clk_stop_ff[`CSP_CS_STOP] ? csp_pkg::CSP_DEEP
                                                : csp_pkg::CSP_HELD;
      csp_pkg::CSP_HELD:
        if (wake)
          nxt_state = csp_pkg::CSP_IDLE;
      csp_pkg::CSP_DEEP:
        if (wake)
          nxt_state = csp_pkg::CSP_RESYNC;
      csp_pkg::CSP_RESYNC:
        if (resync_ff == 4'h0)
          nxt_state = csp_pkg::CSP_IDLE;
      default:
        nxt_state = csp_pkg::CSP_IDLE;
    endcase
  end

  assign ms_restart = (state_ff == csp_pkg::CSP_DEEP) && wake;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_ff  <= csp_pkg::CSP_IDLE;
      resync_ff <= 4'h0;
    end
    else if (ce_i)
    begin
      state_ff <= nxt_state;
      if (ms_restart)
        resync_ff <= clk_stop_ff[`CSP_CS_DELAY_LSB +: 4];
      else if (tickms && resync_ff != 4'h0)
        resync_ff <= resync_ff - 4'h1;
    end
  end

  csp_modcnt #(
    .W (8)
  ) u_mod (
    .clock_i   (clock_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .run_i     (mod_en && !speedup && state_ff == csp_pkg::CSP_IDLE),
    .tick_i    (tick32),
    .off_cnt_i (mod_off_ff),
    .on_cnt_i  (mod_on_ff),
    .assert_o  (mod_assert)
  );

  // Deep suspend pin: level seen after reset is its inactive level.
  logic [1:0] strap_cnt_ff;
  logic       strap_ff;
  logic       strap_done_ff;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      strap_cnt_ff  <= 2'h0;
      strap_ff      <= 1'b0;
      strap_done_ff <= 1'b0;
    end
    else if (ce_i && !strap_done_ff)
    begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == `CSP_STRAP_WAIT)
      begin
        strap_ff      <= deep_pin_q;
        strap_done_ff <= 1'b1;
      end
    end
  end

  // Output registers.
  logic active_idle;
  logic in_cpu_suspend_request_n;
  assign in_cpu_suspend_request_n     = (state_ff != csp_pkg::CSP_IDLE);
  assign active_idle = ack_q && (state_ff == csp_pkg::CSP_IDLE) && !mod_assert;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cpu_suspend_request_n_o      <= 1'b1;
      mgmt_interrupt_n_o           <= 1'b1;
      deep_suspend_clock_gate_o    <= 1'b0;
      deep_suspend_clock_gate_oe_o <= 1'b0;
      core_clock_gate_o            <= 1'b0;
      isa_clock_gate_o             <= 1'b0;
      cpu_power_down_o             <= 1'b0;
      bm_req_o                     <= '0;
    end
    else if (ce_i)
    begin
      cpu_suspend_request_n_o <= ~((nxt_state != csp_pkg::CSP_IDLE) ||
                                   (state_ff == csp_pkg::CSP_IDLE && mod_assert));
      mgmt_interrupt_n_o      <= ~(smi_q || nxt_state == csp_pkg::CSP_RESYNC);
      deep_suspend_clock_gate_o <= (nxt_state == csp_pkg::CSP_DEEP) ? ~strap_ff
                                                                     : strap_ff;
      deep_suspend_clock_gate_oe_o <= strap_done_ff;
      core_clock_gate_o <= active_idle && !cpu_suspend_request_n_cfg_ff[`CSP_SC_SAVE_OFF];
      isa_clock_gate_o  <= active_idle && !cpu_suspend_request_n_cfg_ff[`CSP_SC_SAVE_OFF]
                           && cpu_suspend_request_n_cfg_ff[`CSP_SC_ISA_GATE];
      cpu_power_down_o  <= cpu_suspend_request_n_cfg_ff[`CSP_SC_3V_MODE] && in_cpu_suspend_request_n
                           && (state_ff != csp_pkg::CSP_REQ);
      bm_req_o          <= bm_req_i;
    end
  end

endmodule : csp_ctrl

`default_nettype wire

// ---- include/csp_cfg.svh ----
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH

// Configuration-space functions.
`define CSP_FUNC_CTRL      1'b0
`define CSP_FUNC_WIN       1'b1

// Register indices.
`define CSP_OFS_WIN_BASE   8'h10
`define CSP_OFS_IRQ_SPD    8'h8c
`define CSP_OFS_MOD_OFF    8'h94
`define CSP_OFS_MOD_ON     8'h95
`define CSP_OFS_CPU_SUSPEND_REQUEST_N_CFG   8'h96
`define CSP_OFS_CPU_SUSPEND_REQUEST_N_CMD   8'hae
`define CSP_OFS_CLK_STOP   8'hbc

// Reset values.
`define CSP_RST_WIN_BASE   24'h000000
`define CSP_RST_BYTE       8'h00

// Suspend configuration fields.
`define CSP_SC_MOD_EN      0
`define CSP_SC_SMI_HOLD    1
`define CSP_SC_3V_MODE     2
`define CSP_SC_ISA_GATE    3
`define CSP_SC_SAVE_OFF    4
`define CSP_SC_USED_MASK   8'h1f

// Clock stop control fields.
`define CSP_CS_STOP        0
`define CSP_CS_DELAY_LSB   4
`define CSP_CS_USED_MASK   8'hf1

// Power management window layout.
`define CSP_WIN_LSB        8
`define CSP_WIN_SPD_CLR    8'h08
`define CSP_WIN_TIMER_HI   4'hf

// Timing.
`define CSP_CLK_MHZ        250
`define CSP_MOD_TICK_US    32
`define CSP_MS_US          1000
`define CSP_TICK32_CYC     (`CSP_MOD_TICK_US * `CSP_CLK_MHZ)
`define CSP_MS_CYC         (`CSP_MS_US * `CSP_CLK_MHZ)
`define CSP_STRAP_WAIT     2'h3

`endif

// ---- include/csp_pkg.sv ----
package csp_pkg;

  typedef enum logic [2:0] {
    CSP_IDLE,
    CSP_REQ,
    CSP_HELD,
    CSP_DEEP,
    CSP_RESYNC
  } csp_state_e;

  typedef logic [7:0] csp_byte_t;

endpackage : csp_pkg

// ---- hdl/csp_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

// Two-stage synchroniser; the first stage feeds only the second.
module csp_sync #(
  parameter int unsigned     W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic          clock_i,
  input  wire logic          resetn_i,
  input  wire logic          ce_i,
  input  wire logic [W-1:0]  d_i,
  output logic      [W-1:0]  q_o
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta_ff <= RST;
      q_o     <= RST;
    end
    else if (ce_i)
    begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end

endmodule : csp_sync

`default_nettype wire

// ---- hdl/csp_modcnt.sv ----
`timescale 1ns/1ns
`default_nettype none

// Suspend modulation: alternates an asserted phase of off_cnt_i+1 ticks and a
// released phase of on_cnt_i+1 ticks while run_i is high.
module csp_modcnt #(
  parameter int unsigned W = 8
) (
  input  wire logic          clock_i,
  input  wire logic          resetn_i,
  input  wire logic          ce_i,
  input  wire logic          run_i,
  input  wire logic          tick_i,
  input  wire logic [W-1:0]  off_cnt_i,
  input  wire logic [W-1:0]  on_cnt_i,
  output logic               assert_o
);

  logic [W-1:0] cnt_ff;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_ff   <= '0;
      assert_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!run_i)
      begin
        cnt_ff   <= '0;
        assert_o <= 1'b0;
      end
      else if (tick_i)
      begin
        if (cnt_ff == '0)
        begin
          assert_o <= ~assert_o;
          cnt_ff   <= assert_o ? on_cnt_i : off_cnt_i;
        end
        else
        begin
          cnt_ff <= cnt_ff - 1'b1;
        end
      end
    end
  end

endmodule : csp_modcnt

`default_nettype wire

// ---- sim/csp_ctrl_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module csp_ctrl_props #(
  parameter int unsigned BM_W = 4
) (
  input  wire logic            clock_i,
  input  wire logic            resetn_i,
  input  wire logic            ce_i,
  input  wire logic            mem_rd_i,
  input  wire logic            mem_hit_o,
  input  wire logic            cpu_suspend_ack_n_i,
  input  wire logic            cpu_interrupt_request_i,
  input  wire logic            irq_unmasked_i,
  input  wire logic            mgmt_interrupt_event_i,
  input  wire logic [BM_W-1:0] bm_req_i,
  input  wire logic [BM_W-1:0] bm_req_o,
  input  wire logic            cpu_suspend_request_n_o,
  input  wire logic            mgmt_interrupt_n_o,
  input  wire logic            deep_suspend_clock_gate_i,
  input  wire logic            deep_suspend_clock_gate_o,
  input  wire logic            deep_suspend_clock_gate_oe_o
);
  logic       strap_ff;
  logic [2:0] since_rst_ff;
  logic       deep_act;
  // The pin level seen while undriven is the inactive level.
  assign deep_act = deep_suspend_clock_gate_oe_o && (deep_suspend_clock_gate_o != strap_ff);
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i) since_rst_ff <= 3'h0;
    else if (since_rst_ff != 3'h7) since_rst_ff <= since_rst_ff + 3'h1;
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i) strap_ff <= 1'b0;
    else if (!deep_suspend_clock_gate_oe_o) strap_ff <= deep_suspend_clock_gate_i;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  chk_bm_copy: assert property (ce_i |=> bm_req_o == $past(bm_req_i))
    else $error("bus master copy lost");
  chk_deep_after_ack: assert property ($rose(deep_act) |->
    !cpu_suspend_request_n_o && !$past(cpu_suspend_ack_n_i, 3))
    else $error("deep suspend without handshake");
  chk_wake_drop_req: assert property ((cpu_interrupt_request_i || mgmt_interrupt_event_i)
    && !cpu_suspend_request_n_o && mgmt_interrupt_n_o && !deep_act
    |-> ##[1:5] (cpu_suspend_request_n_o || !mgmt_interrupt_n_o))
    else $error("request kept after wake");
  chk_smi_resync: assert property ($rose(mgmt_interrupt_n_o) |-> cpu_suspend_request_n_o)
    else $error("management interrupt dropped early");
  chk_wake_ends_deep: assert property ((irq_unmasked_i || mgmt_interrupt_event_i)
    && deep_act |-> ##[1:4] !deep_act)
    else $error("deep suspend kept after wake");
  chk_strap_level: assert property ($rose(deep_suspend_clock_gate_oe_o) |->
    deep_suspend_clock_gate_o == $past(deep_suspend_clock_gate_i, 2))
    else $error("pin driven off strap level");
  chk_pin_input: assert property (deep_suspend_clock_gate_oe_o |-> since_rst_ff >= 3'h5)
    else $error("pin driven too soon");
  chk_hit_cause: assert property (mem_hit_o |-> $past(mem_rd_i))
    else $error("window hit without read");
  cover property ($rose(deep_act));
  cover property ($fell(cpu_suspend_request_n_o));
  cover property ($rose(mgmt_interrupt_n_o));
endmodule : csp_ctrl_props
bind csp_ctrl csp_ctrl_props #(.BM_W(BM_W)) csp_ctrl_props_i (.*);
`default_nettype wire

// ---- sim/csp_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module csp_host_model (
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       halt_i,
  input  wire logic       pci_req_i,
  input  wire logic [3:0] dly_i,
  input  wire logic       req_n_i,
  input  wire logic       wake_i,
  output logic            ack_n_o
);
  logic [3:0] cnt_ff;
  logic       want;
  assign want = (halt_i || !req_n_i) && !wake_i && !pci_req_i;
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i)
    begin
      cnt_ff  <= 4'h0;
      ack_n_o <= 1'b1;
    end
    else if (!want)
    begin
      cnt_ff  <= 4'h0;
      ack_n_o <= 1'b1;
    end
    else if (cnt_ff < dly_i) cnt_ff <= cnt_ff + 4'h1;
    else ack_n_o <= 1'b0;
endmodule : csp_host_model
`default_nettype wire

// ---- sim/cpu_suspend_power_control_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module cpu_suspend_power_control_test;
  localparam int MSC = 40;
  logic        clock_i = 1'b0;
  logic        clk_32k_i = 1'b0;
  logic        resetn_i, ce_i, cfg_rd_i, cfg_wr_i, cfg_func_i, mem_rd_i, mem_hit_o, halt, pci;
  logic        cpu_suspend_ack_n_i, cpu_interrupt_request_i, irq_unmasked_i;
  logic        mgmt_interrupt_event_i, cpu_suspend_request_n_o, mgmt_interrupt_n_o;
  logic        deep_suspend_clock_gate_i, deep_suspend_clock_gate_o, deep_suspend_clock_gate_oe_o;
  logic        core_clock_gate_o, isa_clock_gate_o, cpu_power_down_o;
  logic [3:0]  bm_req_i, bm_req_o, dly;
  logic [7:0]  cfg_addr_i;
  logic [31:0] cfg_wdata_i, cfg_rdata_o, mem_addr_i, mem_rdata_o, t0, d;
  int          err_count, comparisons, n;
  assign deep_suspend_clock_gate_i = deep_suspend_clock_gate_oe_o ? deep_suspend_clock_gate_o : 1'b1;
  always #2 clock_i = ~clock_i;
  always #64 clk_32k_i = ~clk_32k_i;
  csp_ctrl #(.TICK32_CYC(8), .MS_CYC(MSC), .BM_W(4)) csp_ctrl_i (.*);
  csp_host_model csp_host_model_i (
    .clock_i   (clock_i),
    .resetn_i  (resetn_i),
    .halt_i    (halt),
    .pci_req_i (pci),
    .dly_i     (dly),
    .req_n_i   (cpu_suspend_request_n_o),
    .wake_i    (cpu_interrupt_request_i | irq_unmasked_i | mgmt_interrupt_event_i),
    .ack_n_o   (cpu_suspend_ack_n_i)
  );
  task give_verdict;
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task tick(input int c);
    repeat (c) @(negedge clock_i);
  endtask : tick
  task cfg_wr(input logic f, input logic [7:0] a, input logic [31:0] v);
    @(negedge clock_i);
    {cfg_wr_i, cfg_func_i, cfg_addr_i, cfg_wdata_i} = {1'b1, f, a, v};
    @(negedge clock_i);
    cfg_wr_i = 1'b0;
  endtask : cfg_wr
  task cfg_rd(input logic f, input logic [7:0] a, output logic [31:0] v);
    @(negedge clock_i);
    {cfg_rd_i, cfg_func_i, cfg_addr_i} = {1'b1, f, a};
    @(negedge clock_i);
    cfg_rd_i = 1'b0;
    v = cfg_rdata_o;
  endtask : cfg_rd
  task mem_rd(input logic [31:0] a, input logic hit, output logic [31:0] v);
    @(negedge clock_i);
    {mem_rd_i, mem_addr_i} = {1'b1, a};
    @(negedge clock_i);
    mem_rd_i = 1'b0;
    v = mem_rdata_o;
    check(32'(mem_hit_o), 32'(hit));
  endtask : mem_rd
  // Waits for the request (s=0) or the deep pin (s=1) to reach level v.
  task wait_lvl(input int s, input logic v);
    int i;
    for (i = 0; i < 3000; i++)
    begin
      if (((s == 0) ? cpu_suspend_request_n_o : deep_suspend_clock_gate_o) === v) break;
      @(negedge clock_i);
    end
    if (i == 3000)
    begin
      err_count++;
      $display("BAD %0t wait ran out", $time);
      give_verdict();
    end
  endtask : wait_lvl
  task span(input logic v, output int c);
    c = 0;
    while (cpu_suspend_request_n_o === v && c < 3000)
    begin
      c++;
      @(negedge clock_i);
    end
    if (c == 3000)
    begin
      err_count++;
      $display("BAD %0t span ran out", $time);
      give_verdict();
    end
  endtask : span
  initial
  begin
    {resetn_i, cfg_rd_i, cfg_wr_i, cfg_func_i, mem_rd_i, halt, pci} = '0;
    {cpu_interrupt_request_i, irq_unmasked_i, mgmt_interrupt_event_i} = '0;
    {cfg_addr_i, cfg_wdata_i, mem_addr_i, bm_req_i} = '0;
    ce_i = 1'b1;
    dly = 4'h2;
    repeat (12) @(negedge clock_i);
    resetn_i = 1'b1;
    check(32'({cpu_suspend_request_n_o, mgmt_interrupt_n_o, deep_suspend_clock_gate_oe_o}), 32'h6);
    cfg_rd(1'b0, 8'h96, d); check(d, 32'h0);
    cfg_rd(1'b1, 8'h10, d); check(d, 32'h0);
    cfg_wr(1'b0, 8'h96, 32'hff); cfg_rd(1'b0, 8'h96, d); check(d, 32'h1f);
    cfg_wr(1'b0, 8'h96, 32'h0);
    cfg_wr(1'b1, 8'h10, 32'hab12cd34); cfg_rd(1'b1, 8'h10, d); check(d, 32'hab12cd00);
    mem_rd(32'hab12cd04, 1'b1, d); check(d, 32'h0);
    mem_rd(32'hab12ce00, 1'b0, d); check(d, 32'h0);
    bm_req_i = 4'h9;
    tick(2); check(32'(bm_req_o), 32'h9);
    dly = 4'h1;
    cfg_wr(1'b0, 8'h96, 32'h08); halt = 1'b1;
    tick(10); check(32'({core_clock_gate_o, isa_clock_gate_o}), 32'h3);
    cfg_wr(1'b0, 8'h96, 32'h00);
    tick(3); check(32'({core_clock_gate_o, isa_clock_gate_o}), 32'h2);
    pci = 1'b1;
    tick(8); check(32'(core_clock_gate_o), 32'h0);
    pci = 1'b0;
    cfg_wr(1'b0, 8'h96, 32'h10);
    tick(10); check(32'(core_clock_gate_o), 32'h0);
    halt = 1'b0;
    dly = 4'hf;
    cfg_wr(1'b0, 8'h96, 32'h04); cfg_wr(1'b0, 8'hae, 32'h0);
    wait_lvl(0, 1'b0);
    tick(24); check(32'({cpu_power_down_o, deep_suspend_clock_gate_o}), 32'h3);
    cpu_interrupt_request_i = 1'b1;
    tick(6); check(32'(cpu_suspend_request_n_o), 32'h1);
    cpu_interrupt_request_i = 1'b0;
    tick(10); check(32'(cpu_power_down_o), 32'h0);
    dly = 4'h2;
    cfg_wr(1'b0, 8'hbc, 32'h21); cfg_wr(1'b0, 8'hae, 32'h0);
    wait_lvl(1, 1'b0); check(32'(cpu_suspend_request_n_o), 32'h0);
    mem_rd(32'hab12cdfc, 1'b1, t0); tick(200); mem_rd(32'hab12cdfc, 1'b1, d);
    check(32'(d[23:0] > t0[23:0]), 32'h1);
    irq_unmasked_i = 1'b1;
    wait_lvl(1, 1'b1); check(32'(mgmt_interrupt_n_o), 32'h0);
    span(1'b0, n);
    check(32'(n >= 2 * MSC && n <= 2 * MSC + 3), 32'h1);
    irq_unmasked_i = 1'b0;
    cfg_wr(1'b0, 8'hbc, 32'h01); cfg_wr(1'b0, 8'hae, 32'h0);
    wait_lvl(1, 1'b0);
    irq_unmasked_i = 1'b1;
    wait_lvl(1, 1'b1); span(1'b0, n); check(32'(n <= 2), 32'h1);
    irq_unmasked_i = 1'b0;
    cfg_wr(1'b0, 8'hbc, 32'h00);
    cfg_wr(1'b0, 8'h94, 32'h01); cfg_wr(1'b0, 8'h95, 32'h02); cfg_wr(1'b0, 8'h96, 32'h01);
    wait_lvl(0, 1'b0);
    span(1'b0, n); check(32'(n), 32'd16);
    span(1'b1, n); check(32'(n), 32'd24);
    cfg_wr(1'b0, 8'h96, 32'h03);
    mgmt_interrupt_event_i = 1'b1; tick(2); mgmt_interrupt_event_i = 1'b0;
    tick(10);
    n = 0;
    repeat (200)
    begin
      n += int'(!cpu_suspend_request_n_o);
      @(negedge clock_i);
    end
    check(32'(n), 32'h0);
    mem_rd(32'hab12cd08, 1'b1, d);
    wait_lvl(0, 1'b0); check(32'(cpu_suspend_request_n_o), 32'h0);
    cfg_wr(1'b0, 8'h96, 32'h02);
    tick(30);
    mgmt_interrupt_event_i = 1'b1; tick(2); mgmt_interrupt_event_i = 1'b0;
    tick(10); cfg_wr(1'b0, 8'h96, 32'h03);
    wait_lvl(0, 1'b0); check(32'(cpu_suspend_request_n_o), 32'h0);
    cfg_wr(1'b0, 8'h8c, 32'h03); cfg_wr(1'b0, 8'h96, 32'h01);
    mgmt_interrupt_event_i = 1'b1; tick(2); mgmt_interrupt_event_i = 1'b0;
    tick(10);
    n = 0;
    repeat (40)
    begin
      n += int'(!cpu_suspend_request_n_o);
      @(negedge clock_i);
    end
    check(32'(n), 32'h0);
    wait_lvl(0, 1'b0); check(32'(cpu_suspend_request_n_o), 32'h0);
    cfg_wr(1'b0, 8'h96, 32'h00);
    give_verdict();
  end
endmodule : cpu_suspend_power_control_test
`default_nettype wire
